// File: verilog/dbgp_defs.svh
// Register offsets, fields and timing counts
// Behaviour
// R1: BDM moves 17-bit transfers, first/last bit separate
// R2: BDM bit rate at most target clock / 5
// R3: default BDM bit rate 125 kHz; the reset TPER value limits it to 100 kHz
// R4: starts in BDM mode, software selects JTAG
// R5: break output requests halt at instruction boundary
// R6: probe can assert target transfer acknowledge
// R7: halted only when all four status inputs low
// R8: combined status tied to all; bit7-only option
// R9: no trace or real-time status capture
// R10: one enable gates clock, data, break lines
// R11: separate enable for JTAG clock driver
// R12: JTAG clock, data, TDO by direct pin control
// R13: JTAG any bit count, TMS sequenced per bit; the code shifts 1 to 32 bits per transfer
// R14: TMS valid at every JTAG sampling edge
// R15: TRST driven from test reset override only
// R16: target reset output drives target device reset
// R17: debug event inverted, optional, per-target enable
`ifndef DBGP_DEFS_SVH
`define DBGP_DEFS_SVH

`define DBGP_ADDR_W        8
`define DBGP_OFF_CTRL      8'h00
`define DBGP_OFF_HALF      8'h04
`define DBGP_OFF_TPER      8'h08
`define DBGP_OFF_TX        8'h0C
`define DBGP_OFF_RX        8'h10
`define DBGP_OFF_JCNT      8'h14
`define DBGP_OFF_JTDI      8'h18
`define DBGP_OFF_JTMS      8'h1C
`define DBGP_OFF_JTDO      8'h20
`define DBGP_OFF_STATUS    8'h24
`define DBGP_OFF_IRQ_STAT  8'h28
`define DBGP_OFF_IRQ_MASK  8'h2C

`define DBGP_CTRL_W        8
`define DBGP_CTRL_RST      8'h00
`define DBGP_EV_W          4
`define DBGP_EV_BDM_DONE   0
`define DBGP_EV_JTAG_DONE  1
`define DBGP_EV_HALT       2
`define DBGP_EV_DEBUG      3

`define DBGP_BDM_BITS      17
`define DBGP_JTAG_MAX      32
`define DBGP_CLK_KHZ       200000
`define DBGP_BDM_KHZ       125
`define DBGP_TGT_MIN_KHZ   500
`define DBGP_RATE_DIV      5
`define DBGP_HALF_RST      ((`DBGP_CLK_KHZ / `DBGP_BDM_KHZ) / 2)
`define DBGP_TPER_RST      (`DBGP_CLK_KHZ / `DBGP_TGT_MIN_KHZ)

`endif

// File: verilog/dbgp_pkg.sv
// Types shared by the debug probe target port
package dbgp_pkg;

    typedef struct packed {
        logic debug_event_present;
        logic jtag_clock_out_enable;
        logic target_reset;
        logic test_reset_override;
        logic bus_ack;
        logic halt_request;
        logic port_out_enable;
        logic jtag_mode;
    } dbgp_ctrl_type;

    typedef struct packed {
        logic serial_clock_or_test_reset;
        logic serial_data_to_target;
        logic halt_or_mode_select_out;
        logic port_out_enable;
        logic jtag_clock_drive;
        logic jtag_clock_out_enable;
        logic target_reset_line_n_o;
        logic target_reset_line_n_oe;
        logic transfer_ack_n_o;
        logic transfer_ack_n_oe;
    } dbgp_link_out_type;

    typedef struct packed {
        logic       debug_serial_out_line;
        logic [3:0] core_status;
    } dbgp_link_in_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BDM_LEAD,
        ST_BDM_HI,
        ST_BDM_LO,
        ST_BDM_TAIL,
        ST_JTAG_LO,
        ST_JTAG_HI
    } dbgp_state_type;

endpackage : dbgp_pkg

// File: verilog/dbgp_port.sv
// Debug port: serial link, JTAG engine, registers
`timescale 1ns/10ps
`default_nettype none
`include "dbgp_defs.svh"

module dbgp_port #(
    parameter bit HALT_BIT7_ONLY = 1'b0
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Avalon-MM slave
    input  wire logic [`DBGP_ADDR_W-1:0]      avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    output var  logic [31:0]                  avs_readdata,
    output var  logic                         avs_waitrequest,
    // Interrupt
    output var  logic                         irq,
    // Target pins
    input  wire dbgp_pkg::dbgp_link_in_type   link_in,
    output var  dbgp_pkg::dbgp_link_out_type  link_out
);
    import dbgp_pkg::*;

    localparam int HALF_W = 16;
    localparam int NEED_W = 20;

    // Half period, at most target clock / 5 rate
    function automatic logic [HALF_W-1:0] eff_half(
        input logic [HALF_W-1:0] half,
        input logic [HALF_W-1:0] tper
    );
        logic [NEED_W-1:0] need;
        need = (NEED_W'(tper) * NEED_W'(`DBGP_RATE_DIV) + NEED_W'(1)) >> 1;
        if (need > NEED_W'(half)) begin
            eff_half = (need > NEED_W'(16'hFFFF)) ? 16'hFFFF
                     : need[HALF_W-1:0];
        end else begin
            eff_half = half;
        end
        if (eff_half == 16'h0000) begin
            eff_half = 16'h0001;
        end
    endfunction : eff_half

    // Three-stage input sync, taken when 2nd and 3rd agree
    logic [4:0] s1_q, s2_q, s3_q, flt_q, flt_d;

    always_comb begin
        flt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & flt_q);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 5'h1F;
            s2_q  <= 5'h1F;
            s3_q  <= 5'h1F;
            flt_q <= 5'h1F;
        end else begin
            s1_q  <= link_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    logic       din;
    logic [3:0] processor_status;
    assign din = flt_q[4];
    assign processor_status = flt_q[3:0]; // R9

    // Register and bus state
    dbgp_ctrl_type    ctrl_q, ctrl_d;
    logic [HALF_W-1:0] half_q, half_d, tper_q, tper_d;
    logic [16:0]      tx_q, tx_d;
    logic [4:0]       jcnt_q, jcnt_d;
    logic [31:0]      jtdi_q, jtdi_d, jtms_q, jtms_d;
    logic [`DBGP_EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             wait_q, wait_d, irq_q, irq_d;
    logic             halted_q, halted_d, devt_q, devt_d;

    // Engine state
    dbgp_state_type    st_q, st_d;
    logic [HALF_W-1:0] cnt_q, cnt_d;
    logic [5:0]        bit_q, bit_d;
    logic [16:0]       sh_q, sh_d, rx_q, rx_d;
    logic [31:0]       jtdo_q, jtdo_d;
    logic              sck_q, sck_d, sdo_q, sdo_d, tms_q, tms_d;
    logic              bdm_done, jtag_done;
    dbgp_link_out_type lo_d;

    logic wr, start_bdm, start_jtag, idle, halted_now, devt_now;
    logic [`DBGP_EV_W-1:0] ev;

    assign wr   = avs_write & ~wait_q;
    assign idle = (st_q == ST_IDLE);
    assign start_bdm  = wr & idle & ~ctrl_q.jtag_mode
                      & (avs_address == `DBGP_OFF_TX);
    assign start_jtag = wr & idle & ctrl_q.jtag_mode
                      & (avs_address == `DBGP_OFF_JCNT);

    // Halt detect in BDM mode, all low means halted, or status bit 3 low alone when HALT_BIT7_ONLY
    always_comb begin
        if (HALT_BIT7_ONLY) begin
            halted_now = ~processor_status[3] & ~ctrl_q.jtag_mode; // R8
        end else begin
            halted_now = (processor_status == 4'h0) & ~ctrl_q.jtag_mode; // R7 R8
        end
        devt_now = ctrl_q.jtag_mode & ctrl_q.debug_event_present
                 & processor_status[3]; // R17
    end

    always_comb begin
        ev = '0;
        ev[`DBGP_EV_BDM_DONE]  = bdm_done;
        ev[`DBGP_EV_JTAG_DONE] = jtag_done;
        ev[`DBGP_EV_HALT]      = halted_now & ~halted_q;
        ev[`DBGP_EV_DEBUG]     = devt_now & ~devt_q;
    end

    // Register file next values
    always_comb begin
        ctrl_d   = ctrl_q;
        half_d   = half_q;
        tper_d   = tper_q;
        tx_d     = tx_q;
        jcnt_d   = jcnt_q;
        jtdi_d   = jtdi_q;
        jtms_d   = jtms_q;
        mask_d   = mask_q;
        stat_d   = stat_q;
        rdata_d  = 32'h00000000;
        halted_d = halted_now;
        devt_d   = devt_now;
        wait_d   = 1'b1;
        if ((avs_read | avs_write) & wait_q) begin
            wait_d = 1'b0;
        end
        if (wr) begin
            case (avs_address)
                `DBGP_OFF_CTRL: begin
                    ctrl_d = dbgp_ctrl_type'(avs_writedata[`DBGP_CTRL_W-1:0]);
                    if (!idle) begin
                        ctrl_d.jtag_mode = ctrl_q.jtag_mode; // R4
                    end
                end
                `DBGP_OFF_HALF:     half_d = avs_writedata[HALF_W-1:0];
                `DBGP_OFF_TPER:     tper_d = avs_writedata[HALF_W-1:0];
                `DBGP_OFF_TX: begin
                    if (idle) begin
                        tx_d = avs_writedata[16:0];
                    end
                end
                `DBGP_OFF_JCNT: begin
                    if (idle) begin
                        jcnt_d = avs_writedata[4:0];
                    end
                end
                `DBGP_OFF_JTDI: begin
                    if (idle) begin
                        jtdi_d = avs_writedata;
                    end
                end
                `DBGP_OFF_JTMS: begin
                    if (idle) begin
                        jtms_d = avs_writedata; // R13
                    end
                end
                `DBGP_OFF_IRQ_STAT:
                    stat_d = stat_q & ~avs_writedata[`DBGP_EV_W-1:0];
                `DBGP_OFF_IRQ_MASK: mask_d = avs_writedata[`DBGP_EV_W-1:0];
                default: ;
            endcase
        end
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
        if (avs_read & wait_q) begin
            case (avs_address)
                `DBGP_OFF_CTRL:     rdata_d = 32'(ctrl_q);
                `DBGP_OFF_HALF:     rdata_d = 32'(half_q);
                `DBGP_OFF_TPER:     rdata_d = 32'(tper_q);
                `DBGP_OFF_TX:       rdata_d = 32'(tx_q);
                `DBGP_OFF_RX:       rdata_d = 32'(rx_q);
                `DBGP_OFF_JCNT:     rdata_d = 32'(jcnt_q);
                `DBGP_OFF_JTDI:     rdata_d = jtdi_q;
                `DBGP_OFF_JTMS:     rdata_d = jtms_q;
                `DBGP_OFF_JTDO:     rdata_d = jtdo_q;
                `DBGP_OFF_STATUS:
                    rdata_d = {28'h0000000, devt_q, halted_q,
                               ctrl_q.jtag_mode, ~idle};
                `DBGP_OFF_IRQ_STAT: rdata_d = 32'(stat_q);
                `DBGP_OFF_IRQ_MASK: rdata_d = 32'(mask_q);
                default:            rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= dbgp_ctrl_type'(`DBGP_CTRL_RST); // R4
            half_q   <= HALF_W'(`DBGP_HALF_RST); // R3
            tper_q   <= HALF_W'(`DBGP_TPER_RST);
            tx_q     <= 17'h00000;
            jcnt_q   <= 5'h00;
            jtdi_q   <= 32'h00000000;
            jtms_q   <= 32'h00000000;
            stat_q   <= '0;
            mask_q   <= '0;
            rdata_q  <= 32'h00000000;
            wait_q   <= 1'b1;
            irq_q    <= 1'b0;
            halted_q <= 1'b0;
            devt_q   <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            half_q   <= half_d;
            tper_q   <= tper_d;
            tx_q     <= tx_d;
            jcnt_q   <= jcnt_d;
            jtdi_q   <= jtdi_d;
            jtms_q   <= jtms_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            irq_q    <= irq_d;
            halted_q <= halted_d;
            devt_q   <= devt_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq             = irq_q;

    // Serial engine, tick per half bit
    logic              tick;
    logic [HALF_W-1:0] reload;
    assign tick   = (cnt_q == '0);
    assign reload = eff_half(half_q, tper_q) - HALF_W'(1); // R2 R3

    always_comb begin
        st_d      = st_q;
        cnt_d     = tick ? reload : cnt_q - HALF_W'(1);
        bit_d     = bit_q;
        sh_d      = sh_q;
        rx_d      = rx_q;
        jtdo_d    = jtdo_q;
        sck_d     = sck_q;
        sdo_d     = sdo_q;
        tms_d     = tms_q;
        bdm_done  = 1'b0;
        jtag_done = 1'b0;
        case (st_q)
            ST_IDLE: begin
                cnt_d = reload;
                sck_d = 1'b0;
                if (start_bdm) begin
                    sh_d  = avs_writedata[16:0];
                    sdo_d = avs_writedata[16]; // R1
                    bit_d = 6'(`DBGP_BDM_BITS - 1);
                    st_d  = ST_BDM_LEAD;
                end else if (start_jtag) begin
                    bit_d  = 6'h00;
                    jtdo_d = 32'h00000000;
                    sdo_d  = jtdi_q[0]; // R12
                    tms_d  = jtms_q[0]; // R14
                    st_d   = ST_JTAG_LO;
                end
            end
            ST_BDM_LEAD: begin
                if (tick) begin
                    sck_d = 1'b1; // R1
                    st_d  = ST_BDM_HI;
                end
            end
            ST_BDM_HI: begin
                if (tick) begin
                    sck_d = 1'b0;
                    sh_d  = {sh_q[15:0], din};
                    if (bit_q == 6'h00) begin
                        st_d = ST_BDM_TAIL; // R1
                    end else begin
                        sdo_d = sh_q[15];
                        bit_d = bit_q - 6'h01;
                        st_d  = ST_BDM_LO;
                    end
                end
            end
            ST_BDM_LO: begin
                if (tick) begin
                    sck_d = 1'b1;
                    st_d  = ST_BDM_HI;
                end
            end
            ST_BDM_TAIL: begin
                if (tick) begin
                    rx_d     = sh_q; // R1
                    sdo_d    = 1'b0;
                    bdm_done = 1'b1;
                    st_d     = ST_IDLE;
                end
            end
            ST_JTAG_LO: begin
                if (tick) begin
                    sck_d = 1'b1; // R12
                    st_d  = ST_JTAG_HI;
                end
            end
            ST_JTAG_HI: begin
                if (tick) begin
                    sck_d = 1'b0;
                    jtdo_d[bit_q[4:0]] = din; // R12
                    if (bit_q[4:0] == jcnt_q) begin
                        jtag_done = 1'b1; // R13
                        st_d      = ST_IDLE;
                    end else begin
                        bit_d = bit_q + 6'h01;
                        sdo_d = jtdi_q[bit_d[4:0]];
                        tms_d = jtms_q[bit_d[4:0]]; // R13 R14
                        st_d  = ST_JTAG_LO;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // Pin levels
    always_comb begin
        lo_d = '0;
        lo_d.port_out_enable = ctrl_d.port_out_enable; // R10
        lo_d.serial_data_to_target = sdo_d;
        if (ctrl_d.jtag_mode) begin
            lo_d.serial_clock_or_test_reset =
                ~ctrl_d.test_reset_override; // R15
            lo_d.halt_or_mode_select_out = tms_d; // R14
            lo_d.jtag_clock_drive        = sck_d; // R12
            lo_d.jtag_clock_out_enable   =
                ctrl_d.jtag_clock_out_enable; // R11
        end else begin
            lo_d.serial_clock_or_test_reset = sck_d;
            lo_d.halt_or_mode_select_out = ~ctrl_d.halt_request; // R5
        end
        lo_d.target_reset_line_n_o  = 1'b0;
        lo_d.target_reset_line_n_oe = ctrl_d.target_reset; // R16
        lo_d.transfer_ack_n_o       = 1'b0;
        lo_d.transfer_ack_n_oe      = ctrl_d.bus_ack; // R6
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            cnt_q    <= '0;
            bit_q    <= 6'h00;
            sh_q     <= 17'h00000;
            rx_q     <= 17'h00000;
            jtdo_q   <= 32'h00000000;
            sck_q    <= 1'b0;
            sdo_q    <= 1'b0;
            tms_q    <= 1'b0;
            link_out <= dbgp_link_out_type'({1'b1, 1'b0, 1'b1, 7'h00});
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            bit_q    <= bit_d;
            sh_q     <= sh_d;
            rx_q     <= rx_d;
            jtdo_q   <= jtdo_d;
            sck_q    <= sck_d;
            sdo_q    <= sdo_d;
            tms_q    <= tms_d;
            link_out <= lo_d;
        end
    end

endmodule : dbgp_port
`default_nettype wire

// File: sim/dbgp_port_chk.sv
// Port assertions for the debug probe target port
`timescale 1ns/10ps
`default_nettype none
`include "dbgp_defs.svh"
module dbgp_port_chk #(
    parameter bit HALT_BIT7_ONLY = 1'b0
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Avalon-MM
    input  wire logic [`DBGP_ADDR_W-1:0]     avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [31:0]                 avs_readdata,
    input  wire logic                        avs_waitrequest,
    input  wire logic                        irq,
    // Target pins
    input  wire dbgp_pkg::dbgp_link_in_type  link_in,
    input  wire dbgp_pkg::dbgp_link_out_type link_out
);
    import dbgp_pkg::*;
    logic [7:0] ctl_q;
    // Shadow of the control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == `DBGP_OFF_CTRL) begin
            ctl_q <= avs_writedata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    rdata_idle_a: assert property (avs_waitrequest |-> avs_readdata == '0)
        else $error("read data outside answer");
    oe_gate_a: assert property (
        link_out.port_out_enable == ctl_q[1])
        else $error("common enable wrong");
    bus_ack_a: assert property (
        link_out.transfer_ack_n_oe == ctl_q[3])
        else $error("acknowledge drive wrong");
    tgt_reset_a: assert property (
        link_out.target_reset_line_n_oe == ctl_q[5])
        else $error("target reset drive wrong");
    break_line_a: assert property (
        !ctl_q[0] |-> link_out.halt_or_mode_select_out != ctl_q[2])
        else $error("break line wrong");
    test_reset_a: assert property (
        ctl_q[0] |-> link_out.serial_clock_or_test_reset != ctl_q[4])
        else $error("test reset line wrong");
    tck_enable_a: assert property (
        link_out.jtag_clock_out_enable == (ctl_q[6] && ctl_q[0]))
        else $error("clock enable wrong");
    tms_hold_a: assert property (
        link_out.jtag_clock_drive && $past(link_out.jtag_clock_drive)
        |-> $stable(link_out.halt_or_mode_select_out)
            && $stable(link_out.serial_data_to_target))
        else $error("mode select moved while clock high");
    tck_quiet_a: assert property (
        !ctl_q[0] |-> !link_out.jtag_clock_drive)
        else $error("test clock outside its mode");
endmodule : dbgp_port_chk
`default_nettype wire

// File: sim/dbgp_target_model.sv
// Behavioural target debug logic facing the probe port
`timescale 1ns/10ps
`default_nettype none
module dbgp_target_model (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Bench control
    input  wire logic                        jtag_mode,
    input  wire logic                        arm,
    input  wire logic [3:0]                  status_in,
    input  wire logic [31:0]                 reply,
    // Target pins
    input  wire dbgp_pkg::dbgp_link_out_type lo,
    output var  dbgp_pkg::dbgp_link_in_type  li,
    // Observations
    output var  logic [31:0]                 cap_d,
    output var  logic [31:0]                 cap_m,
    output var  int                          period
);
    import dbgp_pkg::*;
    logic sck;
    logic sck_q;
    logic halted_q;
    int   k;
    int   cnt;
    // Clock seen by the target
    assign sck = jtag_mode ? lo.jtag_clock_drive
                           : lo.serial_clock_or_test_reset & lo.port_out_enable;
    // Reply bit per falling edge
    always_comb begin
        li.core_status = halted_q ? 4'h0 : status_in;
        if (jtag_mode)
            li.debug_serial_out_line = (k < 32) ? reply[k] : cnt[0];
        else
            li.debug_serial_out_line = (k < 17) ? reply[16-k] : cnt[0];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q    <= 1'b0;
            halted_q <= 1'b0;
            k        <= 0;
            cnt      <= 0;
            cap_d    <= '0;
            cap_m    <= '0;
            period   <= 0;
        end else begin
            sck_q <= sck;
            cnt   <= cnt + 1;
            if (sck && !sck_q) begin
                period <= cnt;
                cnt    <= 1;
                if (jtag_mode) begin
                    cap_d <= {lo.serial_data_to_target, cap_d[31:1]};
                    cap_m <= {lo.halt_or_mode_select_out, cap_m[31:1]};
                end else
                    cap_d <= {cap_d[30:0], lo.serial_data_to_target};
            end
            if (!sck && sck_q)
                k <= k + 1;
            if (!jtag_mode && lo.port_out_enable && !lo.halt_or_mode_select_out)
                halted_q <= 1'b1;
            if (arm) begin
                k        <= 0;
                halted_q <= 1'b0;
            end
        end
    end
endmodule : dbgp_target_model
`default_nettype wire

// File: sim/debug_probe_target_port_tb.sv
// Self-checking bench for the debug probe target port
`timescale 1ns/10ps
`default_nettype none
`include "dbgp_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module debug_probe_target_port_tb;
    import dbgp_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [7:0]        addr = 8'h00;
    logic              rd_s = 1'b0;
    logic              wr_s = 1'b0;
    logic [31:0]       wdata = 32'h0;
    logic [31:0]       rdata;
    logic              wreq;
    logic              irq;
    dbgp_link_in_type  li;
    dbgp_link_out_type lo;
    logic              jm = 1'b0;
    logic              arm = 1'b0;
    logic [3:0]        st = 4'hF;
    logic [31:0]       rep = 32'h0;
    logic [31:0]       cap_d;
    logic [31:0]       cap_m;
    int                period;
    int                bad_count = 0;
    int                n_compared = 0;
    logic [31:0]       v;
    logic [31:0]       msk;
    int                h;

    always #2.5 clk = ~clk;

    dbgp_port #(.HALT_BIT7_ONLY(1'b0)) DUT (
        .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .irq(irq), .link_in(li), .link_out(lo));
    dbgp_target_model tgt (
        .clk(clk), .rst_n(rst_n), .jtag_mode(jm), .arm(arm), .status_in(st),
        .reply(rep), .lo(lo), .li(li), .cap_d(cap_d), .cap_m(cap_m),
        .period(period));

    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        rd_s  <= !w;
        wr_s  <= w;
        addr  <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        v = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        if (n >= 50) `CHK(wreq, 1'b0)
        @(posedge clk);
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(v, e)
    endtask : rdc
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask : settle
    task automatic go(input logic [31:0] r);
        rep <= r;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
    endtask : go
    task automatic idle();
        int n;
        n = 0;
        do begin
            acc(1'b0, `DBGP_OFF_STATUS, 32'h0);
            n++;
        end while (v[0] !== 1'b0 && n < 500);
        `CHK(v[0], 1'b0)
    endtask : idle
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(lo.halt_or_mode_select_out, 1'b1)
        `CHK(lo.port_out_enable, 1'b0)
        rdc(`DBGP_OFF_CTRL, 32'h0);
        rdc(`DBGP_OFF_HALF, `DBGP_HALF_RST);
        rdc(`DBGP_OFF_TPER, `DBGP_TPER_RST);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0);
        $display("test reset done");
        wr(`DBGP_OFF_HALF, 32'h8);
        wr(`DBGP_OFF_CTRL, 32'h2);
        for (int i = 0; i < 2; i++) begin
            h = (i == 0) ? 1 : 4;
            wr(`DBGP_OFF_TPER, h);
            wr(`DBGP_OFF_IRQ_MASK, (i == 0) ? 32'hF : 32'h0);
            go((i == 0) ? 32'h0001_5A3C : 32'h0000_A5C3);
            msk = (i == 0) ? 32'h0001_2C5A : 32'h0000_D3A5;
            wr(`DBGP_OFF_TX, msk);
            idle();
            `CHK(cap_d[16:0], msk[16:0])
            rdc(`DBGP_OFF_RX, rep);
            h = (5 * h + 1) / 2;
            h = (h > 8) ? h : 8;
            `CHK(period, 2 * h)
            `CHK(irq, i == 0)
            rdc(`DBGP_OFF_IRQ_STAT, 32'h1);
            wr(`DBGP_OFF_IRQ_STAT, 32'h1);
            rdc(`DBGP_OFF_IRQ_STAT, 32'h0);
            `CHK(irq, 1'b0)
        end
        $display("test serial done");
        wr(`DBGP_OFF_IRQ_MASK, 32'hF);
        for (int i = 0; i < 3; i++) begin
            st <= (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'hE;
            settle();
            rdc(`DBGP_OFF_STATUS, 32'h0);
        end
        st <= 4'h0;
        settle();
        rdc(`DBGP_OFF_STATUS, 32'h4);
        rdc(`DBGP_OFF_IRQ_STAT, 32'h4);
        `CHK(irq, 1'b1)
        wr(`DBGP_OFF_IRQ_STAT, 32'hF);
        st <= 4'hF;
        settle();
        wr(`DBGP_OFF_CTRL, 32'h6);
        settle();
        `CHK(lo.halt_or_mode_select_out, 1'b0)
        rdc(`DBGP_OFF_STATUS, 32'h4);
        wr(`DBGP_OFF_CTRL, 32'h2A);
        settle();
        `CHK({lo.transfer_ack_n_oe, lo.transfer_ack_n_o}, 2'b10)
        `CHK({lo.target_reset_line_n_oe, lo.target_reset_line_n_o}, 2'b10)
        $display("test halt done");
        st <= 4'h7;
        jm <= 1'b1;
        wr(`DBGP_OFF_CTRL, 32'hC3);
        wr(`DBGP_OFF_IRQ_STAT, 32'hF);
        for (int i = 0; i < 3; i++) begin
            h = (i == 0) ? 1 : (i == 1) ? 8 : 32;
            msk = 32'hFFFF_FFFF >> (32 - h);
            go(32'h6B2D_C41E);
            wr(`DBGP_OFF_JTDI, 32'hA5C3_96E1);
            wr(`DBGP_OFF_JTMS, 32'h3C0F_5AF0);
            wr(`DBGP_OFF_JCNT, h - 1);
            idle();
            `CHK(cap_d >> (32 - h), 32'hA5C3_96E1 & msk)
            `CHK(cap_m >> (32 - h), 32'h3C0F_5AF0 & msk)
            acc(1'b0, `DBGP_OFF_JTDO, 32'h0);
            `CHK(v & msk, rep & msk)
            rdc(`DBGP_OFF_IRQ_STAT, 32'h2);
            wr(`DBGP_OFF_IRQ_STAT, 32'h2);
        end
        wr(`DBGP_OFF_TX, 32'h0001_FFFF);
        rdc(`DBGP_OFF_STATUS, 32'h2);
        wr(`DBGP_OFF_CTRL, 32'hD3);
        settle();
        `CHK(lo.serial_clock_or_test_reset, 1'b0)
        `CHK(lo.jtag_clock_out_enable, 1'b1)
        st <= 4'hF;
        settle();
        rdc(`DBGP_OFF_STATUS, 32'hA);
        rdc(`DBGP_OFF_IRQ_STAT, 32'h8);
        wr(`DBGP_OFF_IRQ_STAT, 32'hF);
        wr(`DBGP_OFF_CTRL, 32'h43);
        st <= 4'h7;
        settle();
        st <= 4'hF;
        settle();
        rdc(`DBGP_OFF_IRQ_STAT, 32'h0);
        $display("test jtag done");
        wrap_up();
    end
endmodule : debug_probe_target_port_tb

bind dbgp_port dbgp_port_chk #(.HALT_BIT7_ONLY(HALT_BIT7_ONLY)) u_chk (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link_in(link_in),
    .link_out(link_out));
`default_nettype wire
